// File: bench/scm_clock_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module scm_clock_ctrl_monitor #(
    parameter int WARM_BIT = 15
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire scm_pkg::scm_axi_req_s axi_req,
    input wire scm_pkg::scm_axi_rsp_s axi_rsp,
    input wire logic hf_clock,
    input wire logic lf_clock,
    input wire logic stop_release_pin,
    input wire logic irq_req,
    input wire logic [3:0] instr_len,
    input wire scm_pkg::scm_clk_out_s clk_out,
    input wire logic tick_irq_request,
    input wire logic divider_out_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    chk_state_step: assert property ($changed(clk_out.machine_state)
        |-> clk_out.machine_state == $past(clk_out.machine_state) + 2'h1) else $error("state skip");
    chk_wrap_zero: assert property (clk_out.cycle_start
        |-> clk_out.main_tick ##[0:1] clk_out.machine_state == 2'h0) else $error("bad wrap");
    chk_irq_wake: assert property (!clk_out.cpu_clk_en && clk_out.periph_clk_en && irq_req
        |=> clk_out.cpu_clk_en && (clk_out.irq_take || clk_out.resume_next)) else $error("no wake");
    chk_take_excl: assert property (clk_out.irq_take
        |-> clk_out.cpu_clk_en && !clk_out.resume_next) else $error("bad take");
    chk_lf_pins: assert property (clk_out.lf_pins_free |-> !clk_out.lf_osc_run)
        else $error("lf pins busy");
    chk_hf_off: assert property (!clk_out.hf_osc_run && clk_out.periph_clk_en
        |-> clk_out.lf_osc_run) else $error("no clock");
    chk_tick_only: assert property (clk_out.tick_clk_en && !clk_out.periph_clk_en
        |-> !clk_out.cpu_clk_en) else $error("cpu in tick halt");
    chk_tick_req: assert property ($rose(tick_irq_request)
        |-> !$past(clk_out.periph_clk_en) || !$past(clk_out.periph_clk_en, 2))
        else $error("tick request outside halt exit");
endmodule : scm_clock_ctrl_monitor
bind scm_clock_ctrl scm_clock_ctrl_monitor #(.WARM_BIT(WARM_BIT)) scm_clock_ctrl_monitor_i (
    .core_clk(core_clk), .reset_n(reset_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .hf_clock(hf_clock), .lf_clock(lf_clock), .stop_release_pin(stop_release_pin),
    .irq_req(irq_req), .instr_len(instr_len), .clk_out(clk_out),
    .tick_irq_request(tick_irq_request), .divider_out_pin(divider_out_pin));
`default_nettype wire

// File: bench/scm_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module scm_osc_model (
    input wire logic hf_run,
    input wire logic lf_run,
    output logic hf_clock,
    output logic lf_clock
);
    // A stopped resonator gives no edges; case test keeps an unknown enable from sticking
    initial hf_clock = 1'b0;
    initial lf_clock = 1'b0;
    always #125 hf_clock = (hf_run === 1'b1) ? ~hf_clock : 1'b0;
    always #410 lf_clock = (lf_run === 1'b1) ? ~lf_clock : 1'b0;
endmodule : scm_osc_model
`default_nettype wire

// File: bench/test_system_clock_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_mode_controller;
    logic core_clk;
    logic reset_n;
    logic hf;
    logic lf;
    logic irq_req;
    logic took;
    logic resumed;
    logic stop_rel;
    logic tirq_o;
    logic dout;
    logic [3:0] instr_len;
    logic [67:0] e;
    logic [67:0] q[$];
    scm_pkg::scm_axi_req_s req;
    scm_pkg::scm_axi_rsp_s rsp;
    scm_pkg::scm_clk_out_s co;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'hd23e5c7e;
    // Entries: expected mode, irq pulse instead of write, sys_ctrl2 value
    logic [12:0] tbl [12] = '{13'h6c0, 13'h8d0, 13'h700, 13'hae0, 13'hc60, 13'h1070,
        13'hd00, 13'hae0, 13'hef0, 13'hb00, 13'h6c0, 13'h080};
    // Short warm-up keeps deep-stop runs brief
    scm_clock_ctrl #(.WARM_BIT(7)) scm_clock_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
        .axi_req(req), .axi_rsp(rsp), .hf_clock(hf), .lf_clock(lf), .stop_release_pin(stop_rel),
        .irq_req(irq_req), .instr_len(instr_len), .clk_out(co), .tick_irq_request(tirq_o),
        .divider_out_pin(dout));
    scm_osc_model scm_osc_model_i (.hf_run(co.hf_osc_run), .lf_run(co.lf_osc_run),
        .hf_clock(hf), .lf_clock(lf));
    task automatic chk(input logic [33:0] s, input logic [33:0] x);
        cmp_count++;
        if (s !== x) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic close_out;
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {req.awvalid, req.awaddr, req.wvalid, req.wdata, req.wstrb, req.bready} <=
            {1'b1, a, 1'b1, d, 4'hf, 1'b1};
        do begin
            @(posedge core_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic [31:0] m);
        q.push_back({2'b11, m, x});
        {req.arvalid, req.araddr, req.rready} <= {1'b1, a, 1'b1};
        do begin
            @(posedge core_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
        @(posedge core_clk);
    endtask : rd
    task automatic pulse;
        irq_req <= 1'b1;
        @(posedge core_clk);
        irq_req <= 1'b0;
    endtask : pulse
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        instr_len <= 4'($random(seed));
        if (co.irq_take) took <= 1'b1;
        if (co.resume_next) resumed <= 1'b1;
        if (rsp.rvalid && req.rready) begin
            e = q.pop_front();
            chk({rsp.rresp, rsp.rdata} & e[67:34], e[33:0]);
        end
        if (cycles == 40000) begin
            miscompares++;
            close_out;
        end
    end
    initial begin
        {reset_n, irq_req, took, resumed, stop_rel, instr_len, req} = '0;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        chk({33'h0, dout}, 34'h1);
        rd(8'h04, 34'h80, 32'hff);
        rd(8'h0c, 34'h0, 32'hf);
        rd(8'h18, 34'h200000000, 32'hffffffff);
        for (int g = 0; g < 2; g++) begin
            wr(8'h14, 32'(g));
            wr(8'h04, 32'h90);
            rd(8'h0c, 34'h1, 32'hf);
            {took, resumed} <= 2'b00;
            pulse;
            repeat (2) @(posedge core_clk);
            chk({32'h0, took, resumed}, {32'h0, g[0], ~g[0]});
        end
        foreach (tbl[i]) begin
            // Low oscillator comes on first and stays on through the slow modes
            if (tbl[i][8]) pulse;
            else wr(8'h04, {24'h0, tbl[i][7:0]});
            repeat (8) @(posedge core_clk);
            rd(8'h0c, {30'h0, tbl[i][12:9]}, 32'hf);
        end
        wr(8'h08, 32'h0f);
        wr(8'h04, 32'h84);
        rd(8'h0c, 34'h2, 32'hf);
        wait (co.periph_clk_en === 1'b1);
        @(posedge core_clk);
        rd(8'h0c, 34'h0, 32'hf);
        rd(8'h14, 34'h5, 32'h7);
        chk({33'h0, tirq_o}, 34'h1);
        wr(8'h00, 32'h80);
        rd(8'h0c, 34'h9, 32'hf);
        rd(8'h10, 34'h0, 32'h1fffff);
        {resumed, stop_rel} <= 2'b01;
        repeat (6000) @(posedge core_clk);
        rd(8'h0c, 34'h0, 32'hf);
        chk({33'h0, resumed}, 34'h1);
        wait (q.size() == 0);
        close_out;
    end
endmodule : test_system_clock_mode_controller
`default_nettype wire

// File: logic/scm_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "scm_map.svh"

module scm_clock_ctrl #(
    parameter int WARM_BIT = `SCM_WARM_BIT_DEFAULT
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire scm_pkg::scm_axi_req_s axi_req,
    output scm_pkg::scm_axi_rsp_s axi_rsp,
    input wire logic hf_clock,
    input wire logic lf_clock,
    input wire logic stop_release_pin,
    input wire logic irq_req,
    input wire logic [3:0] instr_len,
    output scm_pkg::scm_clk_out_s clk_out,
    output logic tick_irq_request,
    output logic divider_out_pin
);

    // Warm-up tap must sit above the stopped low stages and inside the divider
    if (WARM_BIT < `SCM_LOW_STAGES || WARM_BIT >= `SCM_DIV_STAGES) begin : g_bad_warm
        $error("WARM_BIT out of divider range");
    end

    typedef struct packed {
        scm_pkg::scm_mode_e mode;
        logic [2:0][2:0] sync;
        logic [2:0] lvl;
        logic [1:0] presc;
        logic [20:0] div;
        logic tap_prev;
        logic [1:0] mstate;
        logic [3:0] icnt;
        logic warm_fast;
        logic ret_slow;
        logic hf_en;
        logic lf_en;
        logic mclk_sel;
        logic idle_req;
        logic tg_halt;
        logic dv7;
        logic tick_en;
        logic [2:0] tick_sel;
        logic gie;
        logic tie;
        logic tirq;
        logic main_tick;
        logic cycle_start;
        logic instr_done;
        logic irq_take;
        logic resume_next;
        logic div_out;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scm_state_s;

    scm_state_s s_q, s_d;

    function automatic logic tick_tap(input logic [2:0] sel, input logic [20:0] div);
        logic [4:0] idx;
        idx = `SCM_TICK_TAP0;
        case (sel)
            3'h0: idx = `SCM_TICK_TAP0;
            3'h1: idx = `SCM_TICK_TAP1;
            3'h2: idx = `SCM_TICK_TAP2;
            3'h3: idx = `SCM_TICK_TAP3;
            3'h4: idx = `SCM_TICK_TAP4;
            3'h5: idx = `SCM_TICK_TAP5;
            3'h6: idx = `SCM_TICK_TAP6;
            default: idx = `SCM_TICK_TAP7;
        endcase
        return div[idx];
    endfunction : tick_tap

    function automatic logic is_slow(input scm_pkg::scm_mode_e m);
        return m == scm_pkg::SLOW_RUN_HF_ON || m == scm_pkg::SLOW_RUN_HF_OFF ||
               m == scm_pkg::SLOW_HALT_HF_ON || m == scm_pkg::SLOW_HALT_HF_OFF;
    endfunction : is_slow

    function automatic logic valid_ofs(input logic [7:0] a);
        return a == `SCM_SYS_CTRL1_OFS || a == `SCM_SYS_CTRL2_OFS || a == `SCM_TICK_CTRL_OFS ||
               a == `SCM_STATUS_OFS || a == `SCM_DIVIDER_OFS || a == `SCM_IRQ_CTRL_OFS;
    endfunction : valid_ofs

    logic [2:0] rise;
    logic hf_tick, lf_tick, low_run, presc_carry, st6_carry, st7_in, tap_now;
    logic cpu_run, wake, wr_fire, wb;
    logic [31:0] rd_val;
    logic [3:0] len_c;

    always_comb begin
        s_d = s_q;
        s_d.main_tick = 1'b0;
        s_d.cycle_start = 1'b0;
        s_d.instr_done = 1'b0;
        s_d.irq_take = 1'b0;
        s_d.resume_next = 1'b0;

        // Oscillator and stop pins: change accepted once stages two and three agree
        for (int i = 0; i < 3; i++) begin
            s_d.sync[i] = {s_q.sync[i][1:0], 1'b0};
            if (s_q.sync[i][1] == s_q.sync[i][2]) begin
                s_d.lvl[i] = s_q.sync[i][2];
            end
            rise[i] = s_d.lvl[i] & ~s_q.lvl[i];
        end
        s_d.sync[0][0] = hf_clock;
        s_d.sync[1][0] = lf_clock;
        s_d.sync[2][0] = stop_release_pin;
        hf_tick = rise[0];
        lf_tick = rise[1];

        // Prescaler and lower six stages; frozen while hf is stopped and also in slow halt with hf on
        low_run = !(s_q.mode == scm_pkg::SLOW_RUN_HF_OFF || s_q.mode == scm_pkg::SLOW_HALT_HF_ON ||
                    s_q.mode == scm_pkg::SLOW_HALT_HF_OFF || s_q.mode == scm_pkg::DEEP_STOP ||
                    (s_q.mode == scm_pkg::WARM_UP && !s_q.warm_fast));
        presc_carry = low_run && hf_tick && (&s_q.presc);
        st6_carry = presc_carry && (&s_q.div[5:0]);
        if (low_run && hf_tick) begin
            s_d.presc = s_q.presc + 2'h1;
            if (presc_carry) begin
                s_d.div[5:0] = s_q.div[5:0] + 6'h01;
            end
        end
        if (is_slow(s_q.mode) || (s_q.mode == scm_pkg::WARM_UP && !s_q.warm_fast)) begin
            st7_in = lf_tick;
        end else if (s_q.mode == scm_pkg::WARM_UP) begin
            st7_in = st6_carry;
        end else if (s_q.dv7) begin
            st7_in = lf_tick;
        end else begin
            st7_in = st6_carry;
        end
        if (st7_in && s_q.mode != scm_pkg::DEEP_STOP) begin
            s_d.div[20:6] = s_q.div[20:6] + 15'h0001;
        end
        s_d.div_out = s_q.div[`SCM_TICK_TAP7];

        // Main clock: hf in fast run and halt modes, lf in slow modes; none in tick-only halt, deep stop or warm-up
        cpu_run = s_q.mode == scm_pkg::FAST_RUN_SINGLE || s_q.mode == scm_pkg::FAST_RUN_DUAL ||
                  s_q.mode == scm_pkg::SLOW_RUN_HF_ON || s_q.mode == scm_pkg::SLOW_RUN_HF_OFF;
        if (s_q.mode == scm_pkg::DEEP_STOP || s_q.mode == scm_pkg::WARM_UP ||
            s_q.mode == scm_pkg::TICK_ONLY_HALT_FAST) begin
            s_d.main_tick = 1'b0;
        end else if (is_slow(s_q.mode)) begin
            s_d.main_tick = lf_tick;
        end else begin
            s_d.main_tick = hf_tick;
        end
        if (s_d.main_tick) begin
            s_d.mstate = s_q.mstate + 2'h1;
            s_d.cycle_start = s_q.mstate == 2'h3;
        end
        len_c = (instr_len == 4'h0) ? 4'h1 :
                (instr_len > `SCM_MAX_INSTR_CYCLES) ? `SCM_MAX_INSTR_CYCLES : instr_len;
        if (s_d.main_tick && s_q.mstate == 2'h3 && cpu_run) begin
            if (s_q.icnt + 4'h1 >= len_c) begin
                s_d.icnt = 4'h0;
                s_d.instr_done = 1'b1;
            end else begin
                s_d.icnt = s_q.icnt + 4'h1;
            end
        end

        // Register bus
        if (axi_req.awvalid && !s_q.aw_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_q.w_got && !s_q.bvalid) begin
            s_d.w_got = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        wb = s_q.w_strb[0];
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = valid_ofs(s_q.aw_addr) ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
            if (wb && s_q.aw_addr == `SCM_SYS_CTRL1_OFS) begin
                s_d.ret_slow = s_q.w_data[`SCM_RET_SLOW_BIT];
            end
            if (wb && s_q.aw_addr == `SCM_SYS_CTRL2_OFS) begin
                s_d.hf_en = s_q.w_data[`SCM_HF_EN_BIT];
                s_d.lf_en = s_q.w_data[`SCM_LF_EN_BIT];
                s_d.mclk_sel = s_q.w_data[`SCM_MCLK_SEL_BIT];
                s_d.idle_req = s_q.w_data[`SCM_IDLE_BIT];
                s_d.tg_halt = s_q.w_data[`SCM_TG_HALT_BIT];
            end
            if (wb && s_q.aw_addr == `SCM_TICK_CTRL_OFS) begin
                s_d.dv7 = s_q.w_data[`SCM_DV7_BIT];
                s_d.tick_en = s_q.w_data[`SCM_TICK_EN_BIT];
                s_d.tick_sel = s_q.w_data[`SCM_TICK_SEL_LSB +: 3];
            end
            if (wb && s_q.aw_addr == `SCM_IRQ_CTRL_OFS) begin
                s_d.gie = s_q.w_data[`SCM_GIE_BIT];
                s_d.tie = s_q.w_data[`SCM_TIE_BIT];
                if (s_q.w_data[`SCM_TIRQ_BIT]) begin
                    s_d.tirq = 1'b0;
                end
            end
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        rd_val = 32'h0;
        if (axi_req.araddr == `SCM_SYS_CTRL1_OFS) begin
            rd_val[`SCM_RET_SLOW_BIT] = s_q.ret_slow;
        end else if (axi_req.araddr == `SCM_SYS_CTRL2_OFS) begin
            rd_val[`SCM_HF_EN_BIT] = s_q.hf_en;
            rd_val[`SCM_LF_EN_BIT] = s_q.lf_en;
            rd_val[`SCM_MCLK_SEL_BIT] = s_q.mclk_sel;
            rd_val[`SCM_IDLE_BIT] = s_q.idle_req;
            rd_val[`SCM_TG_HALT_BIT] = s_q.tg_halt;
        end else if (axi_req.araddr == `SCM_TICK_CTRL_OFS) begin
            rd_val[`SCM_DV7_BIT] = s_q.dv7;
            rd_val[`SCM_TICK_EN_BIT] = s_q.tick_en;
            rd_val[`SCM_TICK_SEL_LSB +: 3] = s_q.tick_sel;
        end else if (axi_req.araddr == `SCM_STATUS_OFS) begin
            rd_val[7:0] = {2'h0, s_q.mstate, s_q.mode};
        end else if (axi_req.araddr == `SCM_DIVIDER_OFS) begin
            rd_val[20:0] = s_q.div;
        end else if (axi_req.araddr == `SCM_IRQ_CTRL_OFS) begin
            rd_val[`SCM_GIE_BIT] = s_q.gie;
            rd_val[`SCM_TIE_BIT] = s_q.tie;
            rd_val[`SCM_TIRQ_BIT] = s_q.tirq;
        end
        if (axi_req.arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = valid_ofs(axi_req.araddr) ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
        end else if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end

        // Mode sequencing
        wake = irq_req;
        tap_now = tick_tap(s_q.tick_sel, s_q.div);
        s_d.tap_prev = tap_now;
        case (s_q.mode)
            scm_pkg::FAST_RUN_SINGLE, scm_pkg::FAST_RUN_DUAL,
            scm_pkg::SLOW_RUN_HF_ON, scm_pkg::SLOW_RUN_HF_OFF: begin
                if (wr_fire && wb && s_q.aw_addr == `SCM_SYS_CTRL1_OFS &&
                    s_q.w_data[`SCM_DEEP_STOP_BIT]) begin
                    s_d.mode = scm_pkg::DEEP_STOP;
                    s_d.warm_fast = !is_slow(s_q.mode);
                    s_d.presc = 2'h0;
                    s_d.div = 21'h0;
                end else if (s_q.idle_req) begin
                    s_d.idle_req = 1'b0;
                    case (s_q.mode)
                        scm_pkg::FAST_RUN_SINGLE: s_d.mode = scm_pkg::FAST_HALT_SINGLE;
                        scm_pkg::FAST_RUN_DUAL: s_d.mode = scm_pkg::FAST_HALT_DUAL;
                        scm_pkg::SLOW_RUN_HF_ON: s_d.mode = scm_pkg::SLOW_HALT_HF_ON;
                        default: s_d.mode = scm_pkg::SLOW_HALT_HF_OFF;
                    endcase
                end else if (s_q.tg_halt && !is_slow(s_q.mode)) begin
                    s_d.mode = scm_pkg::TICK_ONLY_HALT_FAST;
                end else if (s_q.mode == scm_pkg::FAST_RUN_SINGLE) begin
                    if (s_q.lf_en) begin
                        s_d.mode = scm_pkg::FAST_RUN_DUAL;
                    end
                end else if (s_q.mode == scm_pkg::FAST_RUN_DUAL) begin
                    if (!s_q.lf_en) begin
                        s_d.mode = scm_pkg::FAST_RUN_SINGLE;
                    end else if (s_q.mclk_sel) begin
                        s_d.mode = scm_pkg::SLOW_RUN_HF_ON;
                    end
                end else if (s_q.mode == scm_pkg::SLOW_RUN_HF_ON) begin
                    if (!s_q.mclk_sel) begin
                        s_d.mode = scm_pkg::FAST_RUN_DUAL;
                    end else if (!s_q.hf_en) begin
                        s_d.mode = scm_pkg::SLOW_RUN_HF_OFF;
                    end
                end else begin
                    if (s_q.hf_en) begin
                        s_d.mode = scm_pkg::SLOW_RUN_HF_ON;
                    end
                end
            end
            scm_pkg::FAST_HALT_SINGLE, scm_pkg::FAST_HALT_DUAL,
            scm_pkg::SLOW_HALT_HF_ON, scm_pkg::SLOW_HALT_HF_OFF: begin
                if (wake) begin
                    case (s_q.mode)
                        scm_pkg::FAST_HALT_SINGLE: s_d.mode = scm_pkg::FAST_RUN_SINGLE;
                        scm_pkg::FAST_HALT_DUAL: s_d.mode = scm_pkg::FAST_RUN_DUAL;
                        scm_pkg::SLOW_HALT_HF_ON: s_d.mode = scm_pkg::SLOW_RUN_HF_ON;
                        default: s_d.mode = scm_pkg::SLOW_RUN_HF_OFF;
                    endcase
                    s_d.irq_take = s_q.gie;
                    s_d.resume_next = !s_q.gie;
                end
            end
            scm_pkg::TICK_ONLY_HALT_FAST: begin
                if (s_q.tap_prev && !tap_now) begin
                    s_d.mode = s_q.lf_en ? scm_pkg::FAST_RUN_DUAL : scm_pkg::FAST_RUN_SINGLE;
                    s_d.tg_halt = 1'b0;
                    if (s_q.tick_en) begin
                        s_d.tirq = 1'b1;
                    end
                end
            end
            scm_pkg::DEEP_STOP: begin
                if (rise[2]) begin
                    s_d.mode = scm_pkg::WARM_UP;
                    s_d.presc = 2'h0;
                    s_d.div = 21'h0;
                end
            end
            scm_pkg::WARM_UP: begin
                if (s_q.div[WARM_BIT]) begin
                    s_d.resume_next = 1'b1;
                    if (!s_q.warm_fast) begin
                        s_d.mode = scm_pkg::SLOW_RUN_HF_OFF;
                        s_d.hf_en = 1'b0;
                    end else if (s_q.ret_slow && s_q.lf_en) begin
                        s_d.mode = scm_pkg::SLOW_RUN_HF_OFF;
                        s_d.hf_en = 1'b0;
                        s_d.mclk_sel = 1'b1;
                    end else begin
                        s_d.mode = s_q.lf_en ? scm_pkg::FAST_RUN_DUAL : scm_pkg::FAST_RUN_SINGLE;
                    end
                end
            end
            default: s_d.mode = scm_pkg::FAST_RUN_SINGLE;
        endcase

        // Service the tick request when both enables allow; latch stays set
        if (s_q.tirq && s_q.gie && s_q.tie && cpu_run && s_q.mode == s_d.mode &&
            !s_q.irq_take) begin
            s_d.irq_take = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.mode <= scm_pkg::FAST_RUN_SINGLE;
            s_q.hf_en <= 1'b1;
            s_q.presc <= 2'h0;
            s_q.div <= 21'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // Gating decodes straight from the registered mode, with warm_fast and lf_en also steering the oscillator outputs
    always_comb begin
        clk_out.cpu_clk_en = cpu_run;
        clk_out.wdt_clk_en = cpu_run;
        clk_out.periph_clk_en = cpu_run || s_q.mode == scm_pkg::FAST_HALT_SINGLE ||
                                s_q.mode == scm_pkg::FAST_HALT_DUAL ||
                                s_q.mode == scm_pkg::SLOW_HALT_HF_ON ||
                                s_q.mode == scm_pkg::SLOW_HALT_HF_OFF;
        clk_out.tick_clk_en = s_q.mode != scm_pkg::DEEP_STOP && s_q.mode != scm_pkg::WARM_UP;
        clk_out.hf_osc_run = !(s_q.mode == scm_pkg::SLOW_RUN_HF_OFF ||
                               s_q.mode == scm_pkg::SLOW_HALT_HF_OFF ||
                               s_q.mode == scm_pkg::DEEP_STOP ||
                               (s_q.mode == scm_pkg::WARM_UP && !s_q.warm_fast));
        clk_out.lf_osc_run = s_q.lf_en && s_q.mode != scm_pkg::DEEP_STOP;
        clk_out.lf_pins_free = !s_q.lf_en;
        clk_out.main_tick = s_q.main_tick;
        clk_out.machine_state = s_q.mstate;
        clk_out.cycle_start = s_q.cycle_start;
        clk_out.instr_done = s_q.instr_done;
        clk_out.irq_take = s_q.irq_take;
        clk_out.resume_next = s_q.resume_next;
        axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
        axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
        axi_rsp.bvalid = s_q.bvalid;
        axi_rsp.bresp = s_q.bresp;
        axi_rsp.arready = !s_q.rvalid;
        axi_rsp.rvalid = s_q.rvalid;
        axi_rsp.rdata = s_q.rdata;
        axi_rsp.rresp = s_q.rresp;
    end

    assign tick_irq_request = s_q.tirq;
    // Divider output pin is driven low-active from a divider tap
    assign divider_out_pin = ~s_q.div_out;

endmodule : scm_clock_ctrl
`default_nettype wire

// File: logic/scm_map.svh
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

// Register byte offsets
`define SCM_SYS_CTRL1_OFS 8'h00
`define SCM_SYS_CTRL2_OFS 8'h04
`define SCM_TICK_CTRL_OFS 8'h08
`define SCM_STATUS_OFS 8'h0c
`define SCM_DIVIDER_OFS 8'h10
`define SCM_IRQ_CTRL_OFS 8'h14

// sys_ctrl1 fields
`define SCM_DEEP_STOP_BIT 7
`define SCM_RET_SLOW_BIT 5

// sys_ctrl2 fields
`define SCM_HF_EN_BIT 7
`define SCM_LF_EN_BIT 6
`define SCM_MCLK_SEL_BIT 5
`define SCM_IDLE_BIT 4
`define SCM_TG_HALT_BIT 2
`define SCM_SYS_CTRL2_RST 8'h80

// tick_ctrl fields
`define SCM_DV7_BIT 7
`define SCM_TICK_EN_BIT 3
`define SCM_TICK_SEL_LSB 0

// irq_ctrl fields
`define SCM_GIE_BIT 0
`define SCM_TIE_BIT 1
`define SCM_TIRQ_BIT 2

// Divider bits watched by tick_source_select 0..7
`define SCM_TICK_TAP0 5'd20
`define SCM_TICK_TAP1 5'd18
`define SCM_TICK_TAP2 5'd14
`define SCM_TICK_TAP3 5'd12
`define SCM_TICK_TAP4 5'd11
`define SCM_TICK_TAP5 5'd10
`define SCM_TICK_TAP6 5'd9
`define SCM_TICK_TAP7 5'd7

// Timing
`define SCM_CORE_CLK_NS 25
`define SCM_PRESC_STAGES 2
`define SCM_DIV_STAGES 21
`define SCM_LOW_STAGES 6
`define SCM_STATES_PER_CYCLE 4
`define SCM_MAX_INSTR_CYCLES 4'ha
`define SCM_WARM_BIT_DEFAULT 15

`define SCM_RESP_OKAY 2'b00
`define SCM_RESP_SLVERR 2'b10

`endif

// File: logic/scm_pkg.sv
`default_nettype none
package scm_pkg;

    typedef enum logic [3:0] {
        FAST_RUN_SINGLE = 4'b0000,
        FAST_HALT_SINGLE = 4'b0001,
        TICK_ONLY_HALT_FAST = 4'b0010,
        FAST_RUN_DUAL = 4'b0011,
        FAST_HALT_DUAL = 4'b0100,
        SLOW_RUN_HF_ON = 4'b0101,
        SLOW_RUN_HF_OFF = 4'b0110,
        SLOW_HALT_HF_ON = 4'b0111,
        SLOW_HALT_HF_OFF = 4'b1000,
        DEEP_STOP = 4'b1001,
        WARM_UP = 4'b1010
    } scm_mode_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } scm_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scm_axi_rsp_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic wdt_clk_en;
        logic periph_clk_en;
        logic tick_clk_en;
        logic hf_osc_run;
        logic lf_osc_run;
        logic lf_pins_free;
        logic main_tick;
        logic [1:0] machine_state;
        logic cycle_start;
        logic instr_done;
        logic irq_take;
        logic resume_next;
    } scm_clk_out_s;

endpackage : scm_pkg
`default_nettype wire
